// ---- design/tmr_pkg.sv ----
// Purpose: Shared constants and carrier types for the reload/compare PWM timer
// Assumes: One 200 MHz system clock, synchronous active-high reset
// Notes:   Field positions, codes and the timer and prescaler resets live here
package tmr_pkg;
	localparam int          CLK_PERIOD_NS   = 5;
	localparam int          TMR_WIDTH       = 16;
	localparam int          PRESCALE_WIDTH  = 3;
	localparam int          PRE_CNT_WIDTH   = 7;
	localparam logic [1:0]  CCF_COMPARE     = 2'h0;
	localparam logic        WMS_16BIT       = 1'h0;
	localparam logic [15:0] TIMER_ALL_ONES  = 16'hffff;
	localparam logic [15:0] TIMER_RST       = 16'h0000;
	localparam logic [6:0]  PRE_CNT_RST     = 7'h00;
	localparam int          PIN_PRIMARY     = 0;
	localparam int          PIN_SECONDARY   = 1;

	// Software-side control bits
	typedef struct packed {
		logic                       width_mode_select;
		logic [1:0]                 capture_compare_function;
		logic                       run_control;
		logic [PRESCALE_WIDTH-1:0]  prescale_select;
		logic                       timer_irq_enable;
		logic                       gate_enable;
		logic [1:0]                 pin_output_enables;
		logic [1:0]                 pin_polarity_bits;
	} tmr_ctrl_s;

	// Timer reload and compare words
	typedef struct packed {
		logic [15:0] reload_value;
		logic [15:0] compare_value;
	} tmr_words_s;
endpackage

// ---- design/tmr_pwm.sv ----
// Purpose: 16-bit auto-reload/compare timer with PWM pins, gating and single shot
// Assumes: Control bits are stable ports from same-clock software logic
// Notes:   Primary gate pin is asynchronous and is synchronised first
//
// Summary of operation
// (R1) Compare mode active only when width mode is 16-bit and function bits are 00.
// (R2) Run control starts and stops counting unless single shot overrides.
// (R3) Count clock is system clock divided by prescale ratio.
// (R4) Prescale codes 0..7 give divide ratios 1 to 128 in powers of two.
// (R5) Count upward; on overflow load reload value instead of zero.
// (R6) Overflow flag sets at all-ones overflow; interrupt when enabled.
// (R7) Equality with compare value sets match flag; interrupt when enabled.
// (R8) Compare value outside reload-to-overflow range gives no match.
// (R9) Output clock toggles cycle after match or overflow, once if coincident.
// (R10) Each pin driven only while its output enable bit is set.
// (R11) Pin level is output clock XOR that pin's polarity bit.
// (R12) New polarity takes effect only on output enable rising edge.
// (R13) Primary pin gates only when enable bit 0 clear and gate enable set.
// (R14) Counting blocked while primary pin level equals polarity bit 0.
// (R15) Primary pin may gate while secondary pin outputs gated PWM.
// (R16) Single-shot write runs timer despite cleared run bit until overflow.
// (R17) Single-shot bit clears itself at the ending overflow/reload.
// (R18) Single shot with run set keeps PWM going after shot ends.
// (R19) Software clears gate enable, configures pins, then sets single shot.
// (R20) Gated single shot waits for gate removal, may span gated intervals.
// (R21) After gated shot, continue gated PWM if run set, else stop.
// (R22) Width mode zero selects 16-bit, one selects dual 8-bit operation; here one only leaves compare mode, so the timer stops.
// (R23) Flags stay set until software clears; hardware set wins over clear.
`timescale 1ns/1ps
module tmr_pwm (
	input  wire logic                 i_clock,
	input  wire logic                 i_rst,
	input  wire tmr_pkg::tmr_ctrl_s   i_ctrl,
	input  wire tmr_pkg::tmr_words_s  i_words,
	input  wire logic                 i_timer_load,
	input  wire logic [15:0]          i_timer_load_value,
	input  wire logic                 i_single_shot_wr,
	input  wire logic                 i_overflow_flag_clr,
	input  wire logic                 i_match_flag_clr,
	input  wire logic                 i_primary_timer_pin,
	output logic [15:0]               o_timer_value,
	output logic                      o_single_shot,
	output logic                      o_overflow_flag,
	output logic                      o_match_flag,
	output logic                      o_irq,
	output logic                      o_out_clock,
	output logic                      o_primary_timer_pin,
	output logic                      o_primary_timer_pin_oe,
	output logic                      o_secondary_timer_pin,
	output logic                      o_secondary_timer_pin_oe
);

	////////////////////////////////////////////////////////////////////////////
	// Helper: prescale terminal count for a select code

	function automatic logic [6:0] prescale_last(input logic [2:0] sel);
		prescale_last = 7'((8'h01 << sel) - 8'h01); // see (R4)
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Gate pin synchroniser; first stage read only by second

	logic gate_sync1_ff;
	logic gate_sync2_ff;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			gate_sync1_ff <= 1'b0;
			gate_sync2_ff <= 1'b0;
		end else begin
			gate_sync1_ff <= i_primary_timer_pin;
			gate_sync2_ff <= gate_sync1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode, gate and run decode

	logic [15:0] timer_ff;
	logic [6:0]  pre_cnt_ff;
	logic        shot_ff;
	logic        ovf_flag_ff;
	logic        match_flag_ff;
	logic        toggle_req_ff;
	logic        out_clk_ff;
	logic [1:0]  oe_q_ff;
	logic [1:0]  pol_lat_ff;

	wire compare_mode = (i_ctrl.width_mode_select == tmr_pkg::WMS_16BIT) &&
		(i_ctrl.capture_compare_function == tmr_pkg::CCF_COMPARE); // see (R1) (R22)
	wire gate_active  = i_ctrl.gate_enable &&
		!i_ctrl.pin_output_enables[tmr_pkg::PIN_PRIMARY]; // see (R13)
	// Gated while pin matches polarity bit 0; default low pin blocks
	wire gated        = gate_active &&
		(gate_sync2_ff == i_ctrl.pin_polarity_bits[tmr_pkg::PIN_PRIMARY]); // see (R14) (R20)
	wire run_req      = compare_mode && (i_ctrl.run_control || shot_ff); // see (R2) (R16) (R21)
	wire pre_last     = (pre_cnt_ff >= prescale_last(i_ctrl.prescale_select));
	wire tick         = run_req && !gated && pre_last; // see (R3)
	wire at_top       = (timer_ff == tmr_pkg::TIMER_ALL_ONES);
	wire ovf_evt      = tick && at_top; // see (R6)
	// Counting range is reload..all ones; a compare value outside it is masked from matching
	wire in_range     = (i_words.compare_value >= i_words.reload_value); // see (R8)
	wire match_evt    = tick && in_range &&
		(timer_ff == i_words.compare_value); // see (R7)
	wire [15:0] nxt_timer = ovf_evt ? i_words.reload_value : 16'(timer_ff + 16'h0001); // see (R5)
	wire [6:0]  nxt_pre   = (!run_req || gated || pre_last) ? tmr_pkg::PRE_CNT_RST :
		7'(pre_cnt_ff + 7'h01);
	wire [1:0]  oe_rise   = i_ctrl.pin_output_enables & ~oe_q_ff; // see (R12)

	////////////////////////////////////////////////////////////////////////////
	// Prescaler and counter

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pre_cnt_ff <= tmr_pkg::PRE_CNT_RST;
			timer_ff   <= tmr_pkg::TIMER_RST;
		end else begin
			pre_cnt_ff <= nxt_pre;
			if (i_timer_load) begin
				timer_ff <= i_timer_load_value;
			end else if (tick) begin
				timer_ff <= nxt_timer; // see (R5)
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Single shot: write in compare mode sets, ending overflow clears; a write wins

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			shot_ff <= 1'b0;
		end else if (i_single_shot_wr && compare_mode) begin
			shot_ff <= 1'b1; // see (R16)
		end else if (ovf_evt) begin
			shot_ff <= 1'b0; // see (R17) (R18)
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky flags; hardware set beats software clear

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ovf_flag_ff   <= 1'b0;
			match_flag_ff <= 1'b0;
		end else begin
			ovf_flag_ff   <= ovf_evt | (ovf_flag_ff & ~i_overflow_flag_clr); // see (R23) (R6)
			match_flag_ff <= match_evt | (match_flag_ff & ~i_match_flag_clr); // see (R23) (R7)
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output clock: one toggle per event cycle, applied the cycle after

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			toggle_req_ff <= 1'b0;
			out_clk_ff    <= 1'b0;
		end else begin
			toggle_req_ff <= ovf_evt | match_evt; // see (R9)
			out_clk_ff    <= out_clk_ff ^ toggle_req_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Polarity latch; polarity only captured on enable rising edge

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			oe_q_ff    <= 2'h0;
			pol_lat_ff <= 2'h0;
		end else begin
			oe_q_ff    <= i_ctrl.pin_output_enables;
			pol_lat_ff <= (oe_rise & i_ctrl.pin_polarity_bits) |
				(~oe_rise & pol_lat_ff); // see (R12)
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs

	wire nxt_clk  = out_clk_ff ^ toggle_req_ff;
	wire [1:0] nxt_pol = (oe_rise & i_ctrl.pin_polarity_bits) | (~oe_rise & pol_lat_ff);

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_timer_value            <= tmr_pkg::TIMER_RST;
			o_single_shot            <= 1'b0;
			o_overflow_flag          <= 1'b0;
			o_match_flag             <= 1'b0;
			o_irq                    <= 1'b0;
			o_out_clock              <= 1'b0;
			o_primary_timer_pin      <= 1'b0;
			o_primary_timer_pin_oe   <= 1'b0;
			o_secondary_timer_pin    <= 1'b0;
			o_secondary_timer_pin_oe <= 1'b0;
		end else begin
			o_timer_value            <= timer_ff;
			o_single_shot            <= shot_ff;
			o_overflow_flag          <= ovf_flag_ff;
			o_match_flag             <= match_flag_ff;
			o_irq                    <= i_ctrl.timer_irq_enable &
				(ovf_flag_ff | match_flag_ff); // see (R6) (R7)
			o_out_clock              <= nxt_clk;
			o_primary_timer_pin      <= nxt_clk ^ nxt_pol[tmr_pkg::PIN_PRIMARY]; // see (R11)
			o_primary_timer_pin_oe   <= i_ctrl.pin_output_enables[tmr_pkg::PIN_PRIMARY]; // see (R10)
			o_secondary_timer_pin    <= nxt_clk ^ nxt_pol[tmr_pkg::PIN_SECONDARY]; // see (R11) (R15)
			o_secondary_timer_pin_oe <= i_ctrl.pin_output_enables[tmr_pkg::PIN_SECONDARY]; // see (R10)
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_ovf_then_reload;
		ovf_evt ##1 (timer_ff == $past(i_words.reload_value));
	endsequence

	a_reload_on_ovf: assert property (@(posedge i_clock) disable iff (i_rst)
		ovf_evt && !i_timer_load |-> ##1 (timer_ff == $past(i_words.reload_value))) // see (R5)
		else $error("timer did not reload after overflow");
	a_ovf_flag_set: assert property (@(posedge i_clock) disable iff (i_rst)
		ovf_evt |=> ovf_flag_ff) // see (R6)
		else $error("overflow flag missed");
	a_match_flag_set: assert property (@(posedge i_clock) disable iff (i_rst)
		match_evt |=> match_flag_ff) // see (R7)
		else $error("match flag missed");
	a_match_range: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_words.compare_value < i_words.reload_value) |-> !match_evt) // see (R8)
		else $error("match outside counting range");
	// Compare against the cycle before, so back-to-back events each count
	a_toggle_once: assert property (@(posedge i_clock) disable iff (i_rst)
		(ovf_evt || match_evt) |-> ##2 (out_clk_ff != $past(out_clk_ff))) // see (R9)
		else $error("output clock did not toggle once");
	a_shot_ends: assert property (@(posedge i_clock) disable iff (i_rst)
		s_ovf_then_reload |-> (!shot_ff || $past(i_single_shot_wr))) // see (R17)
		else $error("single shot not cleared at overflow");
	a_gate_blocks: assert property (@(posedge i_clock) disable iff (i_rst)
		gated |-> !tick) // see (R14)
		else $error("counted while gated");
	a_stop_count: assert property (@(posedge i_clock) disable iff (i_rst)
		!run_req && !i_timer_load |=> $stable(timer_ff)) // see (R2)
		else $error("timer moved while stopped");
	a_oe_drive: assert property (@(posedge i_clock) disable iff (i_rst)
		1'b1 |=> o_secondary_timer_pin_oe == $past(i_ctrl.pin_output_enables[1])) // see (R10)
		else $error("pin enable mismatch");

	// Flag clear, hold, polarity, refusal, gate and interrupt checks
	a_flag_clear: assert property (@(posedge i_clock) disable iff (i_rst)
		!ovf_evt && i_overflow_flag_clr |=> !ovf_flag_ff) // see (R23)
		else $error("overflow flag not cleared");
	a_flag_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		ovf_flag_ff && !i_overflow_flag_clr |=> ovf_flag_ff) // see (R23)
		else $error("overflow flag dropped");
	a_pol_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		(oe_rise == 2'h0) |=> (pol_lat_ff == $past(pol_lat_ff))) // see (R12)
		else $error("polarity changed without enable edge");
	a_shot_refused: assert property (@(posedge i_clock) disable iff (i_rst)
		i_single_shot_wr && !compare_mode && !shot_ff |=> !shot_ff) // see (R1)
		else $error("single shot taken outside compare mode");
	a_gate_ignored: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ctrl.pin_output_enables[tmr_pkg::PIN_PRIMARY] |-> !gated) // see (R13)
		else $error("gated while primary pin drives");
	a_irq_level: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ctrl.timer_irq_enable && ovf_flag_ff |=> o_irq) // see (R6)
		else $error("interrupt request missing");
endmodule

// ---- verification/tmr_pin_model.sv ----
// Purpose: External circuit on the primary timer pin
// Assumes: The far side always drives a gate level
// Notes:   The device drive wins whenever its enable is high
`timescale 1ns/1ps
module tmr_pin_model (
	input  wire logic i_oe,
	input  wire logic i_dev_level,
	input  wire logic i_ext_level,
	output logic      o_pin
);
	// Wire level from both parties; the gate level only shows while the device is off
	assign o_pin = i_oe ? i_dev_level : i_ext_level;
endmodule

// ---- verification/tmr_pwm_test.sv ----
// Purpose: Self-checking bench for the reload/compare PWM timer
// Assumes: Prescale code 0 outside the divider sweep
// Notes:   Reload sits near all ones to keep periods short
`timescale 1ns/1ps
module tmr_pwm_test;
	logic                i_clock = 1'b0;
	logic                i_rst = 1'b1;
	tmr_pkg::tmr_ctrl_s  c = '0;
	tmr_pkg::tmr_words_s w = '0;
	logic                ld = 1'b0;
	logic [15:0]         ld_v = 16'h0000;
	logic                ss = 1'b0;
	logic                oclr = 1'b0;
	logic                mclr = 1'b0;
	logic                gate_lvl = 1'b0;
	logic                pin;
	logic [15:0]         tv;
	logic                shot, ovf, mat, irq, oclk, p0, p0_oe, p1, p1_oe;
	int                  miscompares = 0;
	int                  checked = 0;
	int                  cycles = 0;
	int                  n;
	logic [15:0]         r, t0;

	tmr_pwm tmr_pwm_i (.i_clock(i_clock), .i_rst(i_rst), .i_ctrl(c), .i_words(w),
		.i_timer_load(ld), .i_timer_load_value(ld_v), .i_single_shot_wr(ss),
		.i_overflow_flag_clr(oclr), .i_match_flag_clr(mclr), .i_primary_timer_pin(pin),
		.o_timer_value(tv), .o_single_shot(shot), .o_overflow_flag(ovf), .o_match_flag(mat),
		.o_irq(irq), .o_out_clock(oclk), .o_primary_timer_pin(p0),
		.o_primary_timer_pin_oe(p0_oe), .o_secondary_timer_pin(p1),
		.o_secondary_timer_pin_oe(p1_oe));
	tmr_pin_model tmr_pin_model_i (.i_oe(p0_oe), .i_dev_level(p0), .i_ext_level(gate_lvl),
		.o_pin(pin));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #2.5 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks; inputs move 1 ns after the edge
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic tick(input int m);
		repeat (m) @(posedge i_clock);
		#1;
	endtask
	task automatic cfg(input logic run, input logic g, input logic [1:0] oe, input logic [1:0] pl);
		c.run_control = run;
		c.gate_enable = g;
		c.pin_output_enables = oe;
		c.pin_polarity_bits = pl;
		tick(1);
	endtask
	task automatic load(input logic [15:0] v);
		ld_v = v;
		ld = 1'b1;
		tick(1);
		ld = 1'b0;
	endtask
	task automatic shot_wr();
		ss = 1'b1;
		tick(1);
		ss = 1'b0;
	endtask
	// Bounded wait; a value never reached shows as a mismatch
	task automatic wait_tv(input logic [15:0] v);
		n = 0;
		while (tv !== v && n < 3000) begin
			tick(1);
			n++;
		end
		chk("wait timer", tv, v);
	endtask
	// Expect the count frozen (e=1) or moving (e=0) over 12 cycles
	task automatic still(input string nm, input logic e);
		t0 = tv;
		tick(12);
		chk(nm, 16'(tv === t0), 16'(e));
	endtask
	// One full reload-to-overflow window: toggles and flags
	task automatic period(input logic [15:0] cmp, input logic [15:0] tog, input logic m);
		logic b;
		w.compare_value = cmp;
		wait_tv(16'hffff);
		tick(1);
		chk("reload", tv, r);
		oclr = 1'b1;
		mclr = 1'b1;
		tick(1);
		oclr = 1'b0;
		mclr = 1'b0;
		tick(2);
		chk("flags clear", 16'({ovf, mat}), 16'h0);
		n = 0;
		repeat (65536 - int'(r)) begin
			b = oclk;
			tick(1);
			n += int'(oclk !== b);
		end
		chk("toggles", 16'(n), tog);
		tick(3);
		chk("flags", 16'({ovf, mat, irq}), 16'({1'b1, m, 1'b1}));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'hb2bd));
		tick(20);
		i_rst = 1'b0;
		chk("reset", tv, 16'h0);
		chk("reset flags", 16'({ovf, mat, irq, shot}), 16'h0);
		c.timer_irq_enable = 1'b1;
		r = 16'hffc0 + 16'($urandom % 16);
		w.reload_value = r;
		w.compare_value = 16'hffff;
		load(16'h1000);
		cfg(1'b1, 1'b0, 2'b00, 2'b00);
		// Every prescale code; first gap after a change is discarded
		for (int s = 0; s < 8; s++) begin
			c.prescale_select = 3'(s);
			for (int j = 0; j < 2; j++) begin
				t0 = tv;
				n = 0;
				while (tv === t0 && n < 300) begin
					tick(1);
					n++;
				end
			end
			chk("gap", 16'(n), 16'h1 << s);
		end
		c.prescale_select = 3'h0;
		c.width_mode_select = 1'b1;
		still("wide mode", 1'b1);
		c.width_mode_select = 1'b0;
		c.capture_compare_function = 2'h1;
		still("ccf mode", 1'b1);
		shot_wr();
		tick(3);
		chk("shot refused", 16'(shot), 16'h0);
		c.capture_compare_function = 2'h0;
		still("running", 1'b0);
		cfg(1'b0, 1'b0, 2'b00, 2'b00);
		still("stopped", 1'b1);
		cfg(1'b1, 1'b0, 2'b00, 2'b00);
		load(r);
		period(r + 16'h8 + 16'($urandom % 16), 16'h2, 1'b1);
		period(16'hffff, 16'h1, 1'b1);
		period(r - 16'h1, 16'h1, 1'b0);
		c.timer_irq_enable = 1'b0;
		tick(3);
		chk("irq off", 16'(irq), 16'h0);
		// Pins with the timer stopped, so the output clock holds
		cfg(1'b0, 1'b0, 2'b00, 2'b10);
		cfg(1'b0, 1'b0, 2'b11, 2'b10);
		tick(3);
		chk("oe on", 16'({p0_oe, p1_oe}), 16'h3);
		chk("pins", 16'({p0, p1}), 16'({oclk, ~oclk}));
		cfg(1'b0, 1'b0, 2'b11, 2'b01);
		tick(3);
		chk("pol held", 16'({p0, p1}), 16'({oclk, ~oclk}));
		cfg(1'b0, 1'b0, 2'b00, 2'b01);
		tick(3);
		chk("oe off", 16'({p0_oe, p1_oe}), 16'h0);
		cfg(1'b0, 1'b0, 2'b11, 2'b01);
		tick(3);
		chk("pol new", 16'({p0, p1}), 16'({~oclk, oclk}));
		// Gating by the primary pin
		cfg(1'b1, 1'b1, 2'b10, 2'b00);
		tick(4);
		still("gated low", 1'b1);
		gate_lvl = 1'b1;
		tick(4);
		still("gate open", 1'b0);
		chk("pb oe", 16'(p1_oe), 16'h1);
		cfg(1'b1, 1'b1, 2'b10, 2'b01);
		tick(4);
		still("gated high", 1'b1);
		cfg(1'b1, 1'b1, 2'b11, 2'b01);
		still("gate ignored", 1'b0);
		// Software shot: gate off and pins set before the shot bit
		cfg(1'b0, 1'b0, 2'b11, 2'b00);
		load(r + 16'h4);
		shot_wr();
		tick(3);
		chk("shot set", 16'(shot), 16'h1);
		wait_tv(r);
		tick(3);
		chk("shot clear", 16'(shot), 16'h0);
		still("shot end", 1'b1);
		c.run_control = 1'b1;
		load(r + 16'h4);
		shot_wr();
		wait_tv(r);
		tick(3);
		chk("shot run", 16'(shot), 16'h0);
		still("pwm on", 1'b0);
		// Gated shot spanning two open intervals
		cfg(1'b0, 1'b1, 2'b10, 2'b00);
		gate_lvl = 1'b0;
		load(r + 16'h8);
		shot_wr();
		tick(4);
		still("shot gated", 1'b1);
		gate_lvl = 1'b1;
		tick(6);
		gate_lvl = 1'b0;
		tick(4);
		still("shot paused", 1'b1);
		chk("shot held", 16'(shot), 16'h1);
		gate_lvl = 1'b1;
		wait_tv(r);
		tick(3);
		still("gated end", 1'b1);
		test_done();
	end
endmodule
